// *** pwm_consts.svh ***
// Constants for the four-channel PWM analog output block
// Operation
// - Four independent PWM channels, each host-writable.
// - Channel zero: 12-bit steps, 6 kHz period.
// - Other three: 8-bit steps, 96 kHz period.
// - New value applies at next period start.
// - Code is signed 16-bit, 7FFF max, 8000 min.
// - Pick duty giving the closest requested voltage.
// - 8-bit channels unipolar; negative codes give zero.
// - 12-bit channel bipolar; code zero is mid-scale.
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

`define PWM_CHANNELS 4
`define HI_RES_CH 0
`define HI_RES_BITS 12
`define LO_RES_BITS 8
`define CODE_BITS 16

`define CLK_FREQ_KHZ 250000
`define STEP_FREQ_KHZ 24576
`define HI_RES_RATE_HZ 6000
`define LO_RES_RATE_HZ 96000
`define HI_RES_STEPS (`STEP_FREQ_KHZ * 1000 / `HI_RES_RATE_HZ)
`define LO_RES_STEPS (`STEP_FREQ_KHZ * 1000 / `LO_RES_RATE_HZ)

// One spare bit so the accumulator plus increment never wraps
`define ACC_W 19
`define ACC_INC 19'h06000
`define ACC_MOD 19'h3D090

`define UNI_ROUND 16'h0040
`define UNI_MSB 15
`define UNI_LSB 7
`define BI_ROUND 17'h00008
`define BI_MSB 16
`define BI_LSB 4
`define SIGN_BIT 15

`endif

// *** pwm_pkg.sv ***
// Types shared by the PWM analog output block
package pwm_pkg;
  typedef logic [15:0] code_t;
  typedef logic [1:0] ch_t;

  typedef struct packed {
    logic valid;
    ch_t ch;
    code_t data;
  } wr_req_s;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] period_start;
  } pwm_out_s;
endpackage

// *** pwm_channel.sv ***
// One PWM channel: step counter, period-latched duty, output flop
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pwm_channel #(
  parameter int unsigned CNT_W = 8,
  parameter int unsigned STEPS = 256
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic [CNT_W:0] duty_i,
  output logic pwm_o,
  output logic wrap_o
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W:0] duty;
    logic out;
  } chan_state_s;

  localparam logic [CNT_W-1:0] LAST = CNT_W'(STEPS - 1);

  chan_state_s state_ff;
  chan_state_s nxt_state;
  logic wrap;

  assign wrap = step_i && (state_ff.cnt == LAST);

  always_comb begin
    nxt_state = state_ff;
    if (step_i) begin
      nxt_state.cnt = wrap ? '0 : state_ff.cnt + 1'h1;
    end
    // Duty only changes at the period boundary so no runt pulse appears
    if (wrap) begin
      nxt_state.duty = duty_i;
    end
    // Duty of 2^CNT_W keeps the line high for the whole period
    nxt_state.out = ({1'h0, nxt_state.cnt} < nxt_state.duty);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pwm_o = state_ff.out;
  assign wrap_o = wrap;
endmodule // pwm_channel

// *** pwm_analog_out.sv ***
// Four-channel PWM analog output: write port, code mapping, step clock
`timescale 1ns/1ps
`include "pwm_consts.svh"
module pwm_analog_out (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pwm_pkg::wr_req_s wr_i,
  input wire pwm_pkg::ch_t rd_ch_i,
  output pwm_pkg::code_t rd_data_o,
  output logic [3:0] pending_o,
  output pwm_pkg::pwm_out_s pwm_o
);

  // Whole state of this module
  typedef struct packed {
    logic [`ACC_W-1:0] acc;
    logic step;
    logic [`PWM_CHANNELS-1:0][`CODE_BITS-1:0] code;
    logic [`PWM_CHANNELS-1:0] pending;
    pwm_pkg::code_t rd_data;
  } top_state_s;

  top_state_s state_ff;
  top_state_s nxt_state;

  logic [`PWM_CHANNELS-1:0] level;
  logic [`PWM_CHANNELS-1:0] wrap;
  logic [`HI_RES_BITS:0] hi_duty;
  logic [`PWM_CHANNELS-1:`HI_RES_CH+1][`LO_RES_BITS:0] lo_duty;
  logic [`ACC_W-1:0] acc_sum;

  // Unipolar mapping for the 8-bit channels.
  // Negative codes saturate at zero duty. Positive codes are rounded to
  // the nearest of 257 duty levels, so 7FFF reaches full-on.
  function automatic logic [`LO_RES_BITS:0] map_unipolar(
    input pwm_pkg::code_t code
  );
    logic [`CODE_BITS-1:0] rounded;
    rounded = code + `UNI_ROUND;
    if (code[`SIGN_BIT]) begin
      map_unipolar = '0;
    end else begin
      map_unipolar = rounded[`UNI_MSB:`UNI_LSB];
    end
  endfunction

  // Bipolar mapping for the 12-bit channel.
  // Flipping the sign bit turns the signed code into an offset binary
  // value, so 8000 gives zero duty, 0000 gives half and 7FFF full.
  function automatic logic [`HI_RES_BITS:0] map_bipolar(
    input pwm_pkg::code_t code
  );
    logic [`CODE_BITS-1:0] offset;
    logic [`CODE_BITS:0] rounded;
    offset = {~code[`SIGN_BIT], code[`SIGN_BIT-1:0]};
    rounded = {1'h0, offset} + `BI_ROUND;
    map_bipolar = rounded[`BI_MSB:`BI_LSB];
  endfunction

  // Fractional step generator.
  // The system clock is not a multiple of the step rate, so a phase
  // accumulator gives an exact average rate at the cost of up to one
  // clock of jitter on each step.
  assign acc_sum = state_ff.acc + `ACC_INC;

  always_comb begin
    nxt_state = state_ff;

    // Step clock shared by every channel keeps both period rates exact
    if (acc_sum >= `ACC_MOD) begin
      nxt_state.acc = acc_sum - `ACC_MOD;
      nxt_state.step = 1'h1;
    end else begin
      nxt_state.acc = acc_sum;
      nxt_state.step = 1'h0;
    end

    // A period boundary retires the pending flag of its channel
    for (int i = 0; i < `PWM_CHANNELS; i++) begin
      if (wrap[i]) begin
        nxt_state.pending[i] = 1'h0;
      end
    end

    // Host write stores the code for the next period.
    // A write landing on the boundary cycle misses that boundary, so its
    // pending flag is set after the clear and waits for the next one.
    if (wr_i.valid) begin
      nxt_state.code[wr_i.ch] = wr_i.data;
      nxt_state.pending[wr_i.ch] = 1'h1;
    end

    nxt_state.rd_data = state_ff.code[rd_ch_i];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Code mapping from the staged values.
  // Reset leaves every code and channel duty at zero: zero duty on the bipolar channel
  // until its first boundary loads mid-scale, and zero volts on the unipolar ones.
  assign hi_duty = map_bipolar(state_ff.code[`HI_RES_CH]);

  genvar g;
  generate
    for (g = `HI_RES_CH + 1; g < `PWM_CHANNELS; g++) begin : g_lo_map
      assign lo_duty[g] = map_unipolar(state_ff.code[g]);
    end
  endgenerate

  // High-resolution channel
  pwm_channel #(
    .CNT_W(`HI_RES_BITS),
    .STEPS(`HI_RES_STEPS)
  ) u_hi_chan (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .step_i(state_ff.step),
    .duty_i(hi_duty),
    .pwm_o(level[`HI_RES_CH]),
    .wrap_o(wrap[`HI_RES_CH])
  );

  // Low-resolution channels
  generate
    for (g = `HI_RES_CH + 1; g < `PWM_CHANNELS; g++) begin : g_lo_chan
      pwm_channel #(
        .CNT_W(`LO_RES_BITS),
        .STEPS(`LO_RES_STEPS)
      ) u_lo_chan (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .step_i(state_ff.step),
        .duty_i(lo_duty[g]),
        .pwm_o(level[g]),
        .wrap_o(wrap[g])
      );
    end
  endgenerate

  // Outputs
  assign rd_data_o = state_ff.rd_data;
  assign pending_o = state_ff.pending;
  assign pwm_o.level = level;
  // Period start is a one-cycle pulse taken straight from the counters
  assign pwm_o.period_start = wrap;

endmodule // pwm_analog_out

// *** pwm_analog_out_assertions.sv ***
// Port checker for the PWM analog output block
`timescale 1ns/1ps
module pwm_analog_out_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pwm_pkg::wr_req_s wr_i,
  input wire pwm_pkg::ch_t rd_ch_i,
  input wire pwm_pkg::code_t rd_data_o,
  input wire logic [3:0] pending_o,
  input wire pwm_pkg::pwm_out_s pwm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr_sel;
    wr_i.valid ##1 rd_ch_i == $past(wr_i.ch);
  endsequence
  chk_rd_back: assert property (s_wr_sel |=> rd_data_o == $past(wr_i.data, 2))
    else $error("bad readback");
  chk_rd_still: assert property (!wr_i.valid ##1 $stable(rd_ch_i) |=> $stable(rd_data_o))
    else $error("readback moved");
  chk_wrap_align: assert property (pwm_o.period_start[0] |-> pwm_o.period_start[1])
    else $error("wrap misaligned");
  for (genvar c = 0; c < 4; c++) begin : g_ch
    chk_pend_set: assert property (wr_i.valid && wr_i.ch == c |=> pending_o[c])
      else $error("pending unset");
    chk_pend_hold: assert property (pending_o[c] && !pwm_o.period_start[c] |=> pending_o[c])
      else $error("pending lost");
    chk_pend_clear: assert property (pwm_o.period_start[c] && !wr_i.valid |=> !pending_o[c])
      else $error("pending stuck");
    chk_wrap_pulse: assert property (pwm_o.period_start[c] |=> !pwm_o.period_start[c])
      else $error("wrap too long");
    chk_pend_idle: assert property (!pending_o[c] && !wr_i.valid |=> !pending_o[c])
      else $error("pending rose");
  end
endmodule // pwm_analog_out_assertions

bind pwm_analog_out pwm_analog_out_assertions chk_u (.clk_i, .rst_n_i, .wr_i, .rd_ch_i,
  .rd_data_o, .pending_o, .pwm_o);

// *** pwm_filter_model.sv ***
// Output filter model: mean level of each PWM line over its period
`timescale 1ns/1ps
module pwm_filter_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pwm_pkg::pwm_out_s pwm_i,
  output int duty_o [4],
  output int per_o [4],
  output int len_o [4]
);
  int hi [4];
  int len [4];
  // Whole-period average stands in for the RC filter; step jitter cancels out
  always @(posedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      hi[c] += pwm_i.level[c];
      len[c]++;
      if (!rst_n_i || pwm_i.period_start[c]) begin
        if (rst_n_i) begin
          duty_o[c] = (hi[c] * (c ? 256 : 4096) + len[c] / 2) / len[c];
          per_o[c]++;
          len_o[c] = len[c];
        end else per_o[c] = 0;
        hi[c] = 0;
        len[c] = 0;
      end
    end
  end
endmodule // pwm_filter_model

// *** four_channel_pwm_analog_out_tb.sv ***
// Self-checking bench for the PWM analog output block
`timescale 1ns/1ps
module four_channel_pwm_analog_out_tb;
  logic clk_i = 0;
  logic rst_n_i = 0;
  pwm_pkg::wr_req_s wr_i = '0;
  pwm_pkg::ch_t rd_ch_i = '0;
  pwm_pkg::code_t rd_data_o;
  logic [3:0] pending_o;
  pwm_pkg::pwm_out_s pwm_o;
  int duty_o [4];
  int per_o [4];
  int len_o [4];
  int fails = 0;
  int checks_done = 0;
  int p;
  pwm_pkg::code_t k [4];
  pwm_pkg::code_t staged [4] = '{default: '0};
  pwm_pkg::code_t live [4] = '{default: '0};
  int exp_last [4];
  pwm_pkg::code_t cor [6] = '{16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF, 16'h003F, 16'h0040};

  pwm_analog_out dut_u (.clk_i, .rst_n_i, .wr_i, .rd_ch_i, .rd_data_o, .pending_o, .pwm_o);
  pwm_filter_model filt_u (.clk_i, .rst_n_i, .pwm_i(pwm_o), .duty_o, .per_o, .len_o);

  always #2 clk_i = ~clk_i;
  always begin
    repeat (95000) @(posedge clk_i);
    fails++;
    wrap_up();
  end

  // Shadow of the code each channel runs; a write on the boundary cycle misses it
  always @(posedge clk_i) begin
    for (int c = 0; c < 4; c++) begin
      if (rst_n_i && pwm_o.period_start[c]) begin
        exp_last[c] = exp_duty(c, live[c]);
        live[c] = staged[c];
      end
    end
    if (wr_i.valid) staged[wr_i.ch] = wr_i.data;
  end

  function automatic int exp_duty(int c, pwm_pkg::code_t d);
    if (c == 0) return (int'(d ^ 16'h8000) + 8) >> 4;
    return d[15] ? 0 : (int'(d) + 64) >> 7;
  endfunction

  // Shortest period in 250 MHz clocks; the step jitter may add one
  function automatic int exp_len(int c);
    return 250000000 / (c ? 96000 : 6000);
  endfunction

  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, g);
    end
  endtask

  task automatic wr(int c, pwm_pkg::code_t d);
    wr_i = '{1'b1, 2'(c), d};
    @(posedge clk_i);
    #1;
  endtask

  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    void'($urandom(8));
    repeat (8) @(posedge clk_i);
    #1;
    check("reset", 0, {rd_data_o, pending_o, pwm_o.level});
    rst_n_i = 1;
    @(posedge clk_i);
    #1;
    k[0] = 16'($urandom);
    wr(0, k[0]);
    for (int i = 0; i < 8; i++) begin
      // Back-to-back writes to the three unipolar channels
      for (int c = 1; c < 4; c++) begin
        k[c] = i < 6 ? cor[(i + c) % 6] : 16'($urandom);
        wr(c, k[c]);
      end
      wr_i.valid = 0;
      rd_ch_i = 2'($urandom_range(3, 0));
      repeat (2) @(posedge clk_i);
      #1;
      check("readback", k[rd_ch_i], rd_data_o);
      wait (pending_o[3:1] === 3'h0);
      #1;
      for (int c = 1; c < 4; c++) check("old duty", exp_last[c], duty_o[c]);
      p = per_o[1];
      wait (per_o[1] != p);
      #1;
      for (int c = 1; c < 4; c++) check("duty", exp_duty(c, k[c]), duty_o[c]);
      for (int c = 1; c < 4; c++) begin
        check("period", exp_len(c), len_o[c] - (len_o[c] == exp_len(c) + 1));
      end
    end
    // First slow period ran on the reset duty, the second on the written code
    wait (per_o[0] >= 2);
    #1;
    check("bipolar duty", exp_duty(0, k[0]), duty_o[0]);
    check("slow period", exp_len(0), len_o[0] - (len_o[0] == exp_len(0) + 1));
    wrap_up();
  end
endmodule // four_channel_pwm_analog_out_tb
